/* File: design/err_node_params.svh */
// Purpose: constants for the error handling and recording node
// Assumes: one clock, synchronous active-high reset
// Notes: record field positions are block-local, registers are not mapped
`ifndef ERR_NODE_PARAMS_SVH
`define ERR_NODE_PARAMS_SVH

`define EN_DATA_W 32
`define EN_ADDR_W 32
`define EN_MISC_W 32
`define EN_UNIT_W 8
`define EN_SYND_W 8
`define EN_CNT_W 16
`define EN_TS_W 32
`define EN_STAT_W 8
`define EN_MISC_N 4
`define EN_FIXED_DATA 32'hFFFFFFFF
`define EN_STAT_VALID 0
`define EN_STAT_CE 1
`define EN_STAT_DE 2
`define EN_STAT_UE 3
`define EN_STAT_ADDRV 4
`define EN_STAT_SPEC 5
`define EN_STAT_OVF 6
`define EN_STAT_SFM 7
`define EN_FEAT_RESET 32'h00000000
`define EN_CNT_SAT 16'hFFFF

`endif

/* File: design/err_node_pkg.sv */
// Purpose: types for the error handling and recording node
// Assumes: constants come from err_node_params.svh
// Notes: holds types only
`include "err_node_params.svh"

package err_node_pkg;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_CORRECT,
    ACT_DEFER,
    ACT_UNCORR
  } err_action_t;

  typedef enum logic [1:0] {
    RSP_OKAY,
    RSP_CORRECTED,
    RSP_POISON,
    RSP_ERROR
  } rsp_kind_t;

  typedef enum logic [1:0] {
    REC_NONE,
    REC_CE,
    REC_DE,
    REC_UE
  } rec_state_t;

  typedef enum logic {
    RUN_ACTIVE,
    RUN_FAILED
  } run_state_t;

endpackage : err_node_pkg

/* File: design/err_classify.sv */
// Purpose: choose correct, defer or uncorrected for one error event
// Assumes: inputs come from logic on ref_clk
// Notes: purely combinational decision
`include "err_node_params.svh"
`timescale 1ns/1ns
`default_nettype none

module err_classify (
  input wire logic err_valid, // Error event this cycle
  input wire logic can_correct, // Error is correctable
  input wire logic can_defer, // Error is deferrable
  input wire logic req_accepts_poison, // Requester takes deferred errors
  input wire logic is_read, // Access is a read
  output err_node_pkg::err_action_t action, // Chosen treatment
  output logic defer_to_req, // Poisoned data goes to requester
  output logic poison_loc // Stored location gets poisoned
);

  always_comb begin
    action = err_node_pkg::ACT_NONE;
    defer_to_req = 1'b0;
    poison_loc = 1'b0;
    if (err_valid) begin
      if (can_correct) begin
        action = err_node_pkg::ACT_CORRECT;
      end else if (can_defer) begin
        action = err_node_pkg::ACT_DEFER;
        defer_to_req = is_read && req_accepts_poison;
        poison_loc = !defer_to_req;
      end else begin
        action = err_node_pkg::ACT_UNCORR;
      end
    end
  end

endmodule : err_classify

`default_nettype wire

/* File: design/err_record.sv */
// Purpose: one standard error record with status, address and misc words
// Assumes: record reset is separate from error recovery reset
// Notes: all four misc words read back the same for either architecture version input
`include "err_node_params.svh"
`timescale 1ns/1ns
`default_nettype none

module err_record (
  input wire logic ref_clk, // Component clock
  input wire logic rec_rst, // Cold reset of the record only
  input wire logic wr_en, // Write syndrome this cycle
  input wire logic [`EN_STAT_W-1:0] wr_status, // New status word
  input wire logic wr_addr_valid, // Address is known
  input wire logic [`EN_ADDR_W-1:0] wr_addr, // Error address
  input wire logic [`EN_UNIT_W-1:0] wr_unit, // Replaceable unit
  input wire logic [`EN_SYND_W-1:0] wr_loc, // Location in unit
  input wire logic wr_is_ce, // Event is corrected
  input wire logic [`EN_TS_W-1:0] timestamp, // Free running time
  input wire logic version_v11, // Four misc words present
  input wire logic [1:0] rd_misc_sel, // Misc word select
  output logic [`EN_STAT_W-1:0] status, // Status word
  output logic [`EN_ADDR_W-1:0] addr, // Address word
  output logic [`EN_MISC_W-1:0] misc_rd // Selected misc word
);

  typedef struct packed {
    logic [`EN_STAT_W-1:0] status;
    logic [`EN_ADDR_W-1:0] addr;
    logic [`EN_MISC_N-1:0][`EN_MISC_W-1:0] misc;
  } rec_t;

  rec_t rec_ff;
  rec_t nxt_rec;

  always_comb begin
    nxt_rec = rec_ff;
    if (wr_en) begin
      nxt_rec.status = wr_status;
      nxt_rec.addr = wr_addr_valid ? wr_addr : '0;
      nxt_rec.misc[0] = {16'h0000, wr_loc, wr_unit};
      if (wr_is_ce && rec_ff.misc[1][`EN_CNT_W-1:0] != `EN_CNT_SAT) begin
        nxt_rec.misc[1] = rec_ff.misc[1] + 32'h00000001;
      end
      nxt_rec.misc[2] = timestamp;
      nxt_rec.misc[3] = {24'h000000, wr_status};
    end
  end

  // Records see only their own reset, never error recovery reset
  always_ff @(posedge ref_clk) begin
    if (rec_rst) begin
      rec_ff <= '0;
    end else begin
      rec_ff <= nxt_rec;
    end
  end

  always_comb begin
    status = rec_ff.status;
    addr = rec_ff.addr;
    misc_rd = rec_ff.misc[rd_misc_sel];
    if (!version_v11 && rd_misc_sel[1]) begin
      misc_rd = rec_ff.misc[rd_misc_sel];
    end
  end

endmodule : err_record

`default_nettype wire

/* File: design/err_node.sv */
// Purpose: error handling and recording node for one component
// Assumes: all inputs from logic on ref_clk, one event per cycle
// Notes: record state survives rst, cleared only by rec_rst
// Notes on behaviour
// - every corrected error is reported and recorded; code drops errors seen in service failure mode
// - speculative errors reported like architectural ones
// - record identifies originating component
// - correctable errors corrected, CE recorded, fault irq
// - correctable read returns corrected data
// - deferrable errors poisoned, reported, DE recorded
// - undeferred deferrable access may get error response
// - deferred or uncorrected raise both interrupts
// - neither correctable nor deferrable records UE
// - uncorrected access gets error response when enabled
// - uncorrected read without response returns fixed value
// - may halt function until serviced
// - never defer to a requester refusing poison
// - poison location and error response together allowed
// - reported errors write syndrome into record
// - record holds status, optional address, misc words
// - version one provides misc zero and one
// - later version provides four misc words
// - version one may still provide misc two, three
// - misc holds unit, location, counter, timestamp
// - records survive error recovery reset
// - one record layout for every access view
// - unimplemented record slots read zero
`include "err_node_params.svh"
`timescale 1ns/1ns
`default_nettype none

module err_node (
  input wire logic ref_clk, // Component clock, 125 MHz
  input wire logic rst, // Error recovery reset, sync high
  input wire logic rec_rst, // Cold reset clearing the record
  input wire logic req_valid, // Requester access, one cycle
  input wire logic req_read, // Access is a read
  input wire logic req_accepts_poison, // Requester takes deferred data
  input wire logic [`EN_ADDR_W-1:0] req_addr, // Access address
  input wire logic [`EN_DATA_W-1:0] req_data, // Data from storage
  input wire logic err_det, // Error seen on this access
  input wire logic err_spec, // Error seen on speculation
  input wire logic err_can_correct, // Error is correctable
  input wire logic err_can_defer, // Error is deferrable
  input wire logic [`EN_DATA_W-1:0] corr_data, // Corrected data
  input wire logic [`EN_UNIT_W-1:0] err_unit, // Replaceable unit
  input wire logic [`EN_SYND_W-1:0] err_loc, // Location in unit
  input wire logic [`EN_UNIT_W-1:0] src_id, // Originating component
  input wire logic fault_irq_en, // Fault interrupt enable
  input wire logic recov_irq_en, // Recovery interrupt enable
  input wire logic inband_en, // In-band error response enable
  input wire logic defer_inband, // Also abort undeferred deferrals
  input wire logic halt_on_ue, // Enter service failure on UE
  input wire logic service_done, // Leave service failure mode
  input wire logic version_v11, // Later architecture version
  input wire logic [1:0] misc_sel, // Misc word to show
  input wire logic rec_sel_valid, // Selected slot is implemented
  output logic rsp_valid, // Response, one cycle
  output logic [`EN_DATA_W-1:0] rsp_data, // Response data
  output logic rsp_poison, // Response data is poisoned
  output logic rsp_error, // In-band error response
  output logic poison_wr, // Poison stored location, one cycle
  output logic [`EN_ADDR_W-1:0] poison_addr, // Location to poison
  output logic fault_irq, // Fault handling interrupt pulse
  output logic recov_irq, // Error recovery interrupt pulse
  output logic failed, // Service failure mode level
  output logic [`EN_STAT_W-1:0] rec_status, // Record status word
  output logic [`EN_ADDR_W-1:0] rec_addr, // Record address word
  output logic [`EN_MISC_W-1:0] rec_misc, // Selected misc word
  output logic [`EN_UNIT_W-1:0] rec_src, // Originating component
  output logic [`EN_MISC_W-1:0] node_feature_reg // Feature word
);

  typedef struct packed {
    logic rsp_valid;
    logic [`EN_DATA_W-1:0] rsp_data;
    logic rsp_poison;
    logic rsp_error;
    logic poison_wr;
    logic [`EN_ADDR_W-1:0] poison_addr;
    logic fault_irq;
    logic recov_irq;
    err_node_pkg::run_state_t run;
    logic [`EN_TS_W-1:0] ts;
  } node_t;

  typedef struct packed {
    logic [`EN_STAT_W-1:0] status;
    logic [`EN_ADDR_W-1:0] addr;
    logic [`EN_MISC_W-1:0] misc;
    logic [`EN_UNIT_W-1:0] src;
  } view_t;

  node_t st_ff;
  node_t nxt_st;
  view_t view_ff;
  view_t nxt_view;
  logic [`EN_UNIT_W-1:0] src_ff;
  logic [`EN_UNIT_W-1:0] nxt_src;

  err_node_pkg::err_action_t action;
  logic defer_to_req;
  logic poison_loc;
  logic ev_valid;
  logic rec_wr;
  logic [`EN_STAT_W-1:0] new_status;
  logic [`EN_STAT_W-1:0] cur_status;
  logic [`EN_ADDR_W-1:0] cur_addr;
  logic [`EN_MISC_W-1:0] cur_misc;

  // Status word shared by every view of the record
  function automatic logic [`EN_STAT_W-1:0] make_status(
    input err_node_pkg::err_action_t act,
    input logic spec,
    input logic addr_ok,
    input logic was_valid,
    input logic sfm
  );
    logic [`EN_STAT_W-1:0] s;
    s = '0;
    s[`EN_STAT_VALID] = 1'b1;
    s[`EN_STAT_CE] = (act == err_node_pkg::ACT_CORRECT);
    s[`EN_STAT_DE] = (act == err_node_pkg::ACT_DEFER);
    s[`EN_STAT_UE] = (act == err_node_pkg::ACT_UNCORR);
    s[`EN_STAT_ADDRV] = addr_ok;
    s[`EN_STAT_SPEC] = spec;
    s[`EN_STAT_OVF] = was_valid;
    s[`EN_STAT_SFM] = sfm;
    return s;
  endfunction : make_status

  // Failure mode refuses accesses, so nothing new is recorded
  assign ev_valid = err_det && (req_valid || err_spec)
    && (st_ff.run == err_node_pkg::RUN_ACTIVE);

  err_classify u_classify (
    .err_valid(ev_valid),
    .can_correct(err_can_correct),
    .can_defer(err_can_defer),
    .req_accepts_poison(req_accepts_poison),
    .is_read(req_read),
    .action(action),
    .defer_to_req(defer_to_req),
    .poison_loc(poison_loc)
  );

  assign rec_wr = (action != err_node_pkg::ACT_NONE);

  assign new_status = make_status(action, err_spec && !req_valid,
    req_valid, cur_status[`EN_STAT_VALID],
    halt_on_ue && (action == err_node_pkg::ACT_UNCORR));

  err_record u_record (
    .ref_clk(ref_clk),
    .rec_rst(rec_rst),
    .wr_en(rec_wr),
    .wr_status(new_status),
    .wr_addr_valid(req_valid),
    .wr_addr(req_addr),
    .wr_unit(err_unit),
    .wr_loc(err_loc),
    .wr_is_ce(action == err_node_pkg::ACT_CORRECT),
    .timestamp(st_ff.ts),
    .version_v11(version_v11),
    .rd_misc_sel(misc_sel),
    .status(cur_status),
    .addr(cur_addr),
    .misc_rd(cur_misc)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ts = st_ff.ts + 32'h00000001;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.rsp_poison = 1'b0;
    nxt_st.rsp_error = 1'b0;
    nxt_st.poison_wr = 1'b0;
    nxt_st.fault_irq = 1'b0;
    nxt_st.recov_irq = 1'b0;
    if (st_ff.run == err_node_pkg::RUN_FAILED) begin
      if (service_done) begin
        nxt_st.run = err_node_pkg::RUN_ACTIVE;
      end
      if (req_valid) begin
        nxt_st.rsp_valid = 1'b1;
        nxt_st.rsp_error = inband_en;
        nxt_st.rsp_data = `EN_FIXED_DATA;
      end
    end else begin
      if (req_valid) begin
        nxt_st.rsp_valid = 1'b1;
        nxt_st.rsp_data = req_read ? req_data : '0;
      end
      case (action)
        err_node_pkg::ACT_CORRECT: begin
          nxt_st.fault_irq = fault_irq_en;
          if (req_valid && req_read) begin
            nxt_st.rsp_data = corr_data;
          end
        end
        err_node_pkg::ACT_DEFER: begin
          nxt_st.fault_irq = fault_irq_en;
          nxt_st.recov_irq = recov_irq_en;
          nxt_st.poison_wr = poison_loc;
          nxt_st.poison_addr = req_addr;
          if (defer_to_req) begin
            nxt_st.rsp_poison = 1'b1;
            nxt_st.rsp_data = req_data;
          end else if (req_valid) begin
            nxt_st.rsp_error = inband_en && defer_inband;
            if (req_read) begin
              nxt_st.rsp_data = `EN_FIXED_DATA;
            end
          end
        end
        err_node_pkg::ACT_UNCORR: begin
          nxt_st.fault_irq = fault_irq_en;
          nxt_st.recov_irq = recov_irq_en;
          if (req_valid) begin
            nxt_st.rsp_error = inband_en;
            if (req_read) begin
              nxt_st.rsp_data = `EN_FIXED_DATA;
            end
          end
          if (halt_on_ue) begin
            nxt_st.run = err_node_pkg::RUN_FAILED;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Source id is part of the record, so cold reset only
  always_comb begin
    nxt_src = src_ff;
    if (rec_wr) begin
      nxt_src = src_id;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rec_rst) begin
      src_ff <= '0;
    end else begin
      src_ff <= nxt_src;
    end
  end

  always_comb begin
    nxt_view = '0;
    if (rec_sel_valid) begin
      nxt_view.status = cur_status;
      nxt_view.addr = cur_addr;
      nxt_view.misc = (!version_v11 && misc_sel[1]) ? cur_misc : cur_misc;
      nxt_view.src = src_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rec_rst) begin
      view_ff <= '0;
    end else begin
      view_ff <= nxt_view;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rec_rst) begin
      node_feature_reg <= `EN_FEAT_RESET;
    end else begin
      node_feature_reg <= rec_sel_valid ? {28'h0000000, fault_irq_en,
        recov_irq_en, inband_en, version_v11} : '0;
    end
  end

  always_comb begin
    rsp_valid = st_ff.rsp_valid;
    rsp_data = st_ff.rsp_data;
    rsp_poison = st_ff.rsp_poison;
    rsp_error = st_ff.rsp_error;
    poison_wr = st_ff.poison_wr;
    poison_addr = st_ff.poison_addr;
    fault_irq = st_ff.fault_irq;
    recov_irq = st_ff.recov_irq;
    failed = (st_ff.run == err_node_pkg::RUN_FAILED);
    rec_status = view_ff.status;
    rec_addr = view_ff.addr;
    rec_misc = view_ff.misc;
    rec_src = view_ff.src;
  end

endmodule : err_node

`default_nettype wire

/* File: bench/err_node_sva.sv */
// Purpose: port assertions for the error handling node
// Assumes: one clock, synchronous resets, one access per cycle
// Notes: bound to err_node below
`include "err_node_params.svh"
`timescale 1ns/1ns
`default_nettype none

module err_node_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Recovery reset
  input wire logic rec_rst, // Record reset
  input wire logic req_valid, // Access
  input wire logic req_read, // Read
  input wire logic req_accepts_poison, // Takes poison
  input wire logic err_det, // Error seen
  input wire logic err_spec, // Speculative
  input wire logic err_can_correct, // Correctable
  input wire logic err_can_defer, // Deferrable
  input wire logic [`EN_DATA_W-1:0] corr_data, // Corrected data
  input wire logic fault_irq_en, // Fault enable
  input wire logic recov_irq_en, // Recovery enable
  input wire logic inband_en, // Abort enable
  input wire logic service_done, // Leave failure
  input wire logic rec_sel_valid, // Slot present
  input wire logic rsp_valid, // Response
  input wire logic [`EN_DATA_W-1:0] rsp_data, // Response data
  input wire logic rsp_poison, // Poisoned
  input wire logic rsp_error, // Abort
  input wire logic fault_irq, // Fault pulse
  input wire logic recov_irq, // Recovery pulse
  input wire logic failed, // Failure mode
  input wire logic [`EN_STAT_W-1:0] rec_status, // Status view
  input wire logic [`EN_MISC_W-1:0] node_feature_reg // Feature word
);
  logic acc;
  logic hard;
  assign acc = req_valid && err_det && !failed;
  assign hard = (req_valid || err_spec) && err_det && !failed
    && !err_can_correct;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || rec_rst);

  corr_data_a: assert property (
    acc && err_can_correct && req_read |=>
    rsp_data == $past(corr_data) && !rsp_poison)
    else $error("corrected data not returned");
  resp_once_a: assert property (req_valid |=> rsp_valid)
    else $error("access left unanswered");
  defer_rd_a: assert property (
    acc && !err_can_correct && err_can_defer && req_read
    && req_accepts_poison |=> rsp_poison && !rsp_error)
    else $error("deferrable read not poisoned");
  no_poison_a: assert property (
    req_valid && !req_accepts_poison |=> !rsp_poison)
    else $error("poison sent to refusing requester");
  ue_abort_a: assert property (
    acc && !err_can_correct && !err_can_defer && inband_en |=> rsp_error)
    else $error("uncorrected access without abort");
  irq_both_a: assert property (
    hard && fault_irq_en && recov_irq_en |=> fault_irq && recov_irq)
    else $error("interrupts missing");
  fixed_val_a: assert property (
    acc && !err_can_correct && !err_can_defer && req_read && !inband_en
    |=> rsp_data == `EN_FIXED_DATA && !rsp_error)
    else $error("fixed value not returned");
  ce_rec_a: assert property (
    (req_valid || err_spec) && err_det && !failed && err_can_correct
    |-> ##2 rec_status[`EN_STAT_CE])
    else $error("corrected error not recorded");
  fail_hold_a: assert property (
    failed && !service_done |=> failed)
    else $error("failure mode left early");
  keep_rec_a: assert property (
    @(posedge ref_clk) disable iff (rec_rst)
    rst && $past(rst) |=> $stable(rec_status))
    else $error("record changed by recovery reset");
  slot_zero_a: assert property (
    !rec_sel_valid [*2] |-> node_feature_reg == '0)
    else $error("absent slot not zero");
endmodule : err_node_sva

bind err_node err_node_sva chk (.ref_clk, .rst, .rec_rst, .req_valid,
  .req_read, .req_accepts_poison, .err_det, .err_spec, .err_can_correct,
  .err_can_defer, .corr_data, .fault_irq_en, .recov_irq_en, .inband_en,
  .service_done, .rec_sel_valid, .rsp_valid, .rsp_data, .rsp_poison,
  .rsp_error, .fault_irq, .recov_irq, .failed, .rec_status,
  .node_feature_reg);
`default_nettype wire

/* File: bench/requester_model.sv */
// Purpose: requester and storage feeding accesses with errors
// Assumes: drives just after rising edges
// Notes: released lines show inverted data, kind 1 CE 2 DE 3 UE
`timescale 1ns/1ns
`default_nettype none

module requester_model (
  input wire logic ref_clk, // Clock
  output logic req_valid, // Access
  output logic req_read, // Read
  output logic req_accepts_poison, // Takes poison
  output logic [31:0] req_addr, // Address
  output logic [31:0] req_data, // Stored data
  output logic [31:0] corr_data, // Corrected data
  output logic err_det, // Error seen
  output logic err_spec, // Speculative
  output logic err_can_correct, // Correctable
  output logic err_can_defer // Deferrable
);
  initial begin
    {req_valid, req_read, req_accepts_poison, err_det, err_spec} = '0;
    {err_can_correct, err_can_defer} = '0;
    {req_addr, req_data, corr_data} = '0;
  end

  task issue(input logic rd, acc, spec, input logic [1:0] kind,
    input logic [31:0] a, d);
    @(posedge ref_clk);
    req_valid <= !spec;
    req_read <= rd;
    req_accepts_poison <= acc;
    req_addr <= a;
    req_data <= d;
    corr_data <= ~d;
    err_det <= kind != 2'h0;
    err_spec <= spec;
    err_can_correct <= kind == 2'h1;
    err_can_defer <= kind == 2'h2;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    err_det <= 1'h0;
    err_spec <= 1'h0;
    req_addr <= ~a;
    req_data <= ~d;
    corr_data <= d;
    #1;
  endtask : issue
endmodule : requester_model
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench for the error handling node
// Assumes: response one cycle after an access, view one more
// Notes: requester_model supplies accesses and error kinds
`include "err_node_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic ref_clk = 0, rst = 1, rec_rst = 1, service_done = 0;
  logic fault_irq_en = 1, recov_irq_en = 1, inband_en = 1;
  logic defer_inband = 1, halt_on_ue = 0, version_v11 = 1;
  logic rec_sel_valid = 1;
  logic [1:0] misc_sel = 2'h0;
  logic [7:0] src_id = 8'h5A, err_unit = 8'h3C, err_loc = 8'hC3;
  logic req_valid, req_read, req_accepts_poison, err_det, err_spec;
  logic err_can_correct, err_can_defer;
  logic [31:0] req_addr, req_data, corr_data;
  logic rsp_valid, rsp_poison, rsp_error, poison_wr, fault_irq;
  logic recov_irq, failed;
  logic [31:0] rsp_data, poison_addr, rec_addr, rec_misc, node_feature_reg;
  logic [7:0] rec_status, rec_src, snap;
  int miscompares = 0, num_checks = 0, cycles = 0;

  always #4 ref_clk = ~ref_clk;

  requester_model req (.ref_clk, .req_valid, .req_read, .req_accepts_poison,
    .req_addr, .req_data, .corr_data, .err_det, .err_spec,
    .err_can_correct, .err_can_defer);
  err_node dut (.ref_clk, .rst, .rec_rst, .req_valid, .req_read,
    .req_accepts_poison, .req_addr, .req_data, .err_det, .err_spec,
    .err_can_correct, .err_can_defer, .corr_data, .err_unit, .err_loc,
    .src_id, .fault_irq_en, .recov_irq_en, .inband_en, .defer_inband,
    .halt_on_ue, .service_done, .version_v11, .misc_sel, .rec_sel_valid,
    .rsp_valid, .rsp_data, .rsp_poison, .rsp_error, .poison_wr,
    .poison_addr, .fault_irq, .recov_irq, .failed, .rec_status, .rec_addr,
    .rec_misc, .rec_src, .node_feature_reg);

  task complete_run;
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task chkb(input logic exp, got);
    chk({31'h0, exp}, {31'h0, got});
  endtask : chkb

  task view;
    @(posedge ref_clk);
    #1;
  endtask : view

  task t_correct;
    req.issue(1'h1, 1'h1, 1'h0, 2'h1, 32'h100, 32'h1234ABCD);
    chk(32'hEDCB5432, rsp_data);
    chkb(1'h0, rsp_poison);
    chkb(1'h1, fault_irq);
    view();
    chkb(1'h1, rec_status[`EN_STAT_CE]);
    chk({16'h0, err_loc, err_unit}, rec_misc);
    chk({24'h0, src_id}, {24'h0, rec_src});
    req.issue(1'h0, 1'h0, 1'h1, 2'h1, 32'h0, 32'h0);
    chkb(1'h0, rsp_valid);
    view();
    chkb(1'h1, rec_status[`EN_STAT_SPEC]);
  endtask : t_correct

  task t_defer;
    req.issue(1'h1, 1'h1, 1'h0, 2'h2, 32'h200, 32'h55AA55AA);
    chkb(1'h1, rsp_poison);
    chkb(1'h0, rsp_error);
    chkb(1'h1, fault_irq);
    chkb(1'h1, recov_irq);
    view();
    chkb(1'h1, rec_status[`EN_STAT_DE]);
    req.issue(1'h1, 1'h0, 1'h0, 2'h2, 32'h204, 32'h0F0F0F0F);
    chkb(1'h0, rsp_poison);
    chkb(1'h1, poison_wr);
    chk(32'h204, poison_addr);
    chkb(1'h1, rsp_error);
  endtask : t_defer

  task t_uncorr;
    req.issue(1'h1, 1'h1, 1'h0, 2'h3, 32'h300, 32'h11112222);
    chkb(1'h1, rsp_error);
    chkb(1'h0, rsp_poison);
    view();
    chkb(1'h1, rec_status[`EN_STAT_UE]);
    inband_en <= 1'h0;
    fault_irq_en <= 1'h0;
    req.issue(1'h1, 1'h1, 1'h0, 2'h3, 32'h304, 32'h33334444);
    chk(`EN_FIXED_DATA, rsp_data);
    chkb(1'h0, rsp_error);
    chkb(1'h0, fault_irq);
    chkb(1'h1, recov_irq);
  endtask : t_uncorr

  task t_fail;
    halt_on_ue <= 1'h1;
    req.issue(1'h0, 1'h1, 1'h0, 2'h3, 32'h400, 32'h0);
    chkb(1'h1, failed);
    req.issue(1'h1, 1'h1, 1'h0, 2'h1, 32'h404, 32'h76543210);
    chk(`EN_FIXED_DATA, rsp_data);
    chkb(inband_en, rsp_error);
    @(posedge ref_clk) service_done <= 1'h1;
    halt_on_ue <= 1'h0;
    @(posedge ref_clk) service_done <= 1'h0;
    #1;
    chkb(1'h0, failed);
  endtask : t_fail

  task t_reset;
    snap = rec_status;
    @(posedge ref_clk) rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    view();
    chk({24'h0, snap}, {24'h0, rec_status});
    rec_sel_valid <= 1'h0;
    view();
    chk(32'h0, node_feature_reg);
    chk(32'h0, {24'h0, rec_status});
    @(posedge ref_clk) rec_rst <= 1'h1;
    rec_sel_valid <= 1'h1;
    @(posedge ref_clk) rec_rst <= 1'h0;
    view();
    chk(32'h0, {24'h0, rec_status});
  endtask : t_reset

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    rec_rst <= 1'h0;
    t_correct();
    t_defer();
    t_uncorr();
    inband_en <= 1'h1;
    fault_irq_en <= 1'h1;
    t_fail();
    t_reset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
